// File: stac_consts.svh
// constants for the spectrometer trigger and acquisition sequencer
`ifndef STAC_CONSTS_SVH
`define STAC_CONSTS_SVH

////////////////////////////////////////////////////////////////////////////////
// register bus
`define STAC_ADDR_W 8
`define STAC_OFS_CTRL 8'h00
`define STAC_OFS_INTEG 8'h04
`define STAC_OFS_CMD 8'h08
`define STAC_OFS_STATUS 8'h0C
`define STAC_OFS_FRAMES 8'h10
`define STAC_OFS_DROPS 8'h14

////////////////////////////////////////////////////////////////////////////////
// field positions
`define STAC_CTRL_RUN 0
`define STAC_CTRL_MODE_LO 1
`define STAC_CTRL_MODE_HI 3
`define STAC_CTRL_IN_POL 4
`define STAC_CTRL_OUT_EN 5
`define STAC_CTRL_OUT_POL 6
`define STAC_CTRL_W 7
`define STAC_CMD_SW_TRIG 0
`define STAC_INTEG_W 17

////////////////////////////////////////////////////////////////////////////////
// reset values
`define STAC_CTRL_RST 7'h50
`define STAC_INTEG_RST 17'h003E8
`define STAC_INTEG_MIN 17'h0001E

////////////////////////////////////////////////////////////////////////////////
// timing
`define STAC_CLK_PERIOD_NS 20
`define STAC_US_NS 1000
`define STAC_US_CYCLES ((`STAC_US_NS + `STAC_CLK_PERIOD_NS - 1) / `STAC_CLK_PERIOD_NS)
`define STAC_PULSE_US 10
`define STAC_PULSE_NS (`STAC_PULSE_US * `STAC_US_NS)
`define STAC_PULSE_CYCLES ((`STAC_PULSE_NS + `STAC_CLK_PERIOD_NS - 1) / `STAC_CLK_PERIOD_NS)

`endif

// File: stac_pkg.sv
// types and mode decoding for the trigger and acquisition sequencer
package stac_pkg;

  typedef enum logic [2:0] {
    STAC_SW_ASYNC = 3'b000,
    STAC_SW_SYNC = 3'b001,
    STAC_EDGE_ASYNC = 3'b010,
    STAC_EDGE_SYNC = 3'b011,
    STAC_LVL_ASYNC = 3'b100,
    STAC_LVL_SYNC = 3'b101
  } stac_mode_t;

  typedef enum logic [1:0] {
    STAC_IDLE = 2'b00,
    STAC_INTEG = 2'b01,
    STAC_CONV = 2'b10
  } stac_state_t;

  typedef struct packed {
    logic out_pol;
    logic out_en;
    logic in_pol;
    logic [2:0] mode;
    logic run;
  } stac_ctrl_t;

  // codes 6 and 7 behave as software asynchronous
  function automatic logic stac_is_sync(logic [2:0] m);
    return m[0] & (m < 3'h6);
  endfunction

  function automatic logic stac_is_lvl(logic [2:0] m);
    return (m == STAC_LVL_ASYNC) | (m == STAC_LVL_SYNC);
  endfunction

  function automatic logic stac_is_edge(logic [2:0] m);
    return (m == STAC_EDGE_ASYNC) | (m == STAC_EDGE_SYNC);
  endfunction

endpackage

// File: stac_trig_if.sv
// trigger terminal signals shared by sequencer, input detector and pulse generator
`timescale 1ns/10ps
interface stac_trig_if;
  logic pin_in;
  logic in_pol;
  logic edge_hit;
  logic level_hit;
  logic pulse_go;
  logic out_pol;
  logic pulse_busy;
  logic pulse_lvl;

  modport det (input pin_in, input in_pol, output edge_hit, output level_hit);
  modport pulse (input pulse_go, input out_pol, output pulse_busy, output pulse_lvl);
  modport ctrl (output pin_in, output in_pol, output pulse_go, output out_pol,
                input edge_hit, input level_hit, input pulse_busy, input pulse_lvl);
endinterface

// File: stac_trig_det.sv
// external trigger edge and level detection
`timescale 1ns/10ps
module stac_trig_det (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // trigger terminal
  stac_trig_if.det tif
);
  logic prev;
  logic primed;

  // no edge is reported in the first cycle after reset
  wire rise = primed & tif.pin_in & ~prev;
  wire fall = primed & ~tif.pin_in & prev;

  assign tif.edge_hit = tif.in_pol ? rise : fall;
  assign tif.level_hit = (tif.pin_in == tif.in_pol);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
      primed <= 1'b0;
    end else begin
      prev <= tif.pin_in;
      primed <= 1'b1;
    end
  end
endmodule

// File: stac_pulse_gen.sv
// fixed width integration start pulse with selectable polarity
`timescale 1ns/10ps
`include "stac_consts.svh"
module stac_pulse_gen (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // pulse request and level
  stac_trig_if.pulse tif
);
  localparam logic [8:0] LAST = 9'(`STAC_PULSE_CYCLES - 1);

  logic busy;
  logic lvl;
  logic [8:0] cnt;

  wire start = tif.pulse_go & ~busy;
  wire next_busy = start | (busy & (cnt != LAST));

  assign tif.pulse_busy = busy;
  assign tif.pulse_lvl = lvl;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      busy <= 1'b0;
      cnt <= 9'h000;
      lvl <= 1'b0;
    end else begin
      busy <= next_busy;
      cnt <= start ? 9'h000 : (busy ? cnt + 9'h001 : cnt);
      lvl <= next_busy ? tif.out_pol : ~tif.out_pol;
    end
  end
endmodule

// File: stac_top.sv
// trigger and acquisition sequencer: modes, trigger filter, integration and delivery
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps
`include "stac_consts.svh"

// Functional notes
// - sw async: deliver first frame converted after command
// - sw sync: command starts a new integration
// - edge async: deliver first frame after edge
// - edge sync: selected edge starts integration
// - level async: deliver frames while level active
// - level sync: active level starts integration
// - drop triggers within one measurement period
// - output fixed width pulse at integration start
// - output pulse polarity is configurable
// - all pixels integrate in one window
module stac_top (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic [`STAC_ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // external trigger terminal
  input wire logic ext_trig_i,
  output logic ext_trig_o,
  output logic ext_trig_oe,
  // sensor and converter
  output logic sensor_integ,
  output logic conv_start,
  input wire logic conv_done,
  // frame delivery
  output logic frame_valid
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  stac_pkg::stac_ctrl_t ctrl;
  stac_pkg::stac_ctrl_t act;
  stac_pkg::stac_ctrl_t cfg;
  stac_pkg::stac_state_t state;
  stac_pkg::stac_state_t next_state;
  logic [`STAC_INTEG_W-1:0] integ_us;
  logic [`STAC_INTEG_W-1:0] integ_cnt;
  logic [5:0] us_cnt;
  logic pending;
  logic [15:0] frames;
  logic [15:0] drops;
  logic out_en;

  stac_trig_if tif ();

  stac_trig_det u_det (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(tif.det)
  );

  stac_pulse_gen u_pulse (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(tif.pulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  wire sel_ctrl = (addr == `STAC_OFS_CTRL);
  wire sel_integ = (addr == `STAC_OFS_INTEG);
  wire sel_cmd = (addr == `STAC_OFS_CMD);
  wire sel_status = (addr == `STAC_OFS_STATUS);
  wire sel_frames = (addr == `STAC_OFS_FRAMES);
  wire sel_drops = (addr == `STAC_OFS_DROPS);
  wire wr_ctrl = wr & sel_ctrl;
  wire wr_integ = wr & sel_integ;
  wire sw_trig = wr & sel_cmd & wdata[`STAC_CMD_SW_TRIG];
  wire [`STAC_INTEG_W-1:0] wr_integ_val = wdata[`STAC_INTEG_W-1:0];
  // shorter than the documented minimum is raised to it
  wire [`STAC_INTEG_W-1:0] integ_clamped =
    (wr_integ_val < `STAC_INTEG_MIN) ? `STAC_INTEG_MIN : wr_integ_val;

  wire [31:0] status_word = {26'h0000000, out_en, tif.pulse_busy, pending, sensor_integ, state};
  wire [31:0] next_rdata =
    sel_ctrl ? {25'h0000000, ctrl} :
    sel_integ ? {15'h0000, integ_us} :
    sel_status ? status_word :
    sel_frames ? {16'h0000, frames} :
    sel_drops ? {16'h0000, drops} : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////////
  // trigger source selection
  // settings act at once while idle, so free running modes pick them up in their idle cycle
  // and the pulse idle level is settled before the next start; a measurement keeps its copy
  assign cfg = (state == stac_pkg::STAC_IDLE) ? ctrl : act;

  wire use_sync = stac_pkg::stac_is_sync(cfg.mode);
  wire use_lvl = stac_pkg::stac_is_lvl(cfg.mode);
  wire use_edge = stac_pkg::stac_is_edge(cfg.mode);
  wire use_sw = ~use_lvl & ~use_edge;
  // the terminal is ignored as an input while it drives the start pulse
  wire ext_ok = cfg.run & ~cfg.out_en;

  assign tif.pin_in = ext_trig_i;
  assign tif.in_pol = cfg.in_pol;
  assign tif.out_pol = cfg.out_pol;

  wire sw_req = use_sw & cfg.run & sw_trig;
  wire edge_req = use_edge & ext_ok & tif.edge_hit;
  wire lvl_req = use_lvl & ext_ok & tif.level_hit;
  wire pulse_req = sw_req | edge_req;
  wire trig_req = pulse_req | lvl_req;

  //////////////////////////////////////////////////////////////////////////////
  // acceptance window
  // a trigger is taken only when no earlier one is still being served
  wire running = (state != stac_pkg::STAC_IDLE);
  wire can_accept = use_sync ? ~running : (running & ~pending);
  wire accept = trig_req & can_accept;
  wire drop = pulse_req & ~can_accept;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer
  wire us_tick = (us_cnt == 6'(`STAC_US_CYCLES - 1));
  wire integ_end = (state == stac_pkg::STAC_INTEG) & us_tick & (integ_cnt == 17'h00001);
  wire conv_end = (state == stac_pkg::STAC_CONV) & conv_done;
  // async modes run free; sync modes wait for an accepted trigger
  wire start_integ = (state == stac_pkg::STAC_IDLE) &
    (use_sync ? accept : cfg.run);
  // only a frame converted after its trigger is delivered
  wire deliver = conv_end & pending;

  always_comb begin
    next_state = state;
    case (state)
      stac_pkg::STAC_IDLE: begin
        if (start_integ) begin
          next_state = stac_pkg::STAC_INTEG;
        end
      end
      stac_pkg::STAC_INTEG: begin
        if (integ_end) begin
          next_state = stac_pkg::STAC_CONV;
        end
      end
      stac_pkg::STAC_CONV: begin
        if (conv_end) begin
          next_state = stac_pkg::STAC_IDLE;
        end
      end
      default: begin
        next_state = stac_pkg::STAC_IDLE;
      end
    endcase
  end

  assign tif.pulse_go = start_integ & cfg.out_en;

  //////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl <= stac_pkg::stac_ctrl_t'(`STAC_CTRL_RST);
      integ_us <= `STAC_INTEG_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= stac_pkg::stac_ctrl_t'(wdata[`STAC_CTRL_W-1:0]);
      end
      if (wr_integ) begin
        integ_us <= integ_clamped;
      end
    end
  end

  // working copy is refreshed only while no measurement runs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      act <= stac_pkg::stac_ctrl_t'(`STAC_CTRL_RST);
      out_en <= 1'b0;
    end else if (state == stac_pkg::STAC_IDLE) begin
      act <= ctrl;
      out_en <= ctrl.out_en;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= stac_pkg::STAC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      us_cnt <= 6'h00;
      integ_cnt <= `STAC_INTEG_MIN;
    end else if (start_integ) begin
      us_cnt <= 6'h00;
      integ_cnt <= integ_us;
    end else if (state == stac_pkg::STAC_INTEG) begin
      us_cnt <= us_tick ? 6'h00 : us_cnt + 6'h01;
      if (us_tick) begin
        integ_cnt <= integ_cnt - 17'h00001;
      end
    end
  end

  // set wins over clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pending <= 1'b0;
    end else if (accept) begin
      pending <= 1'b1;
    end else if (deliver || (!running && !cfg.run)) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      frames <= 16'h0000;
      drops <= 16'h0000;
    end else begin
      frames <= deliver ? frames + 16'h0001 : frames;
      drops <= drop ? drops + 16'h0001 : drops;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sensor_integ <= 1'b0;
      conv_start <= 1'b0;
      frame_valid <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      sensor_integ <= (next_state == stac_pkg::STAC_INTEG);
      conv_start <= integ_end;
      frame_valid <= deliver;
      rdata <= rd ? next_rdata : 32'h00000000;
    end
  end

  assign ext_trig_o = tif.pulse_lvl;
  assign ext_trig_oe = out_en;

endmodule

// File: stac_chk.sv
// assertion checker for the trigger and acquisition sequencer
`timescale 1ns/10ps
module stac_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // register port
  input wire logic rd,
  input wire logic [31:0] rdata,
  // terminal, sensor and delivery
  input wire logic ext_trig_o,
  input wire logic ext_trig_oe,
  input wire logic sensor_integ,
  input wire logic conv_start,
  input wire logic conv_done,
  input wire logic frame_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [15:0] pcnt;
  logic [16:0] icnt;
  // cycles since the terminal level last moved, and length of the window
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pcnt <= 16'h0000;
      icnt <= 17'h00000;
    end else begin
      pcnt <= $changed(ext_trig_o) ? 16'h0000 : pcnt + 16'h0001;
      icnt <= sensor_integ ? icnt + 17'h00001 : 17'h00000;
    end
  end
  sequence s_start;
    $rose(sensor_integ) && ext_trig_oe;
  endsequence
  sequence s_conv;
    conv_start ##1 !conv_start;
  endsequence
  pulse_start_a: assert property (s_start |-> $changed(ext_trig_o)) else $error("no pulse at start");
  pulse_width_a: assert property (sensor_integ && ext_trig_oe && $past(ext_trig_oe) && $changed(ext_trig_o)
    && !$rose(sensor_integ) |-> pcnt == 16'h01F3) else $error("pulse width wrong");
  integ_len_a: assert property ($fell(sensor_integ) |-> icnt >= 17'h005DC) else $error("window short");
  conv_follow_a: assert property ($fell(sensor_integ) |-> s_conv) else $error("no conversion start");
  conv_hold_a: assert property (conv_start |=> !sensor_integ [*8]) else $error("restart in conversion");
  frame_cause_a: assert property (frame_valid |-> $past(conv_done) && !sensor_integ) else $error("stray frame");
  frame_pulse_a: assert property (frame_valid |=> !frame_valid) else $error("frame pulse long");
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 32'h00000000) else $error("read data not zero");
endmodule
bind stac_top stac_chk u_chk (.ref_clk(ref_clk), .resetn(resetn), .rd(rd), .rdata(rdata),
  .ext_trig_o(ext_trig_o), .ext_trig_oe(ext_trig_oe), .sensor_integ(sensor_integ),
  .conv_start(conv_start), .conv_done(conv_done), .frame_valid(frame_valid));

// File: stac_conv_model.sv
// converter model: answers each conversion start after a fixed latency
`timescale 1ns/10ps
module stac_conv_model #(parameter int LAT = 20) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // converter handshake
  input wire logic conv_start,
  output logic conv_done
);
  int cnt;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= (cnt == 1);
      if (conv_start) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// File: tb.sv
// testbench: register access, trigger modes and frame delivery
`timescale 1ns/10ps
`include "stac_consts.svh"
module tb;
  logic ref_clk, resetn, wr, rd, ext_trig_i;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic ext_trig_o, ext_trig_oe, sensor_integ, conv_start, conv_done, frame_valid;
  logic [6:0] tab [7] = '{7'h17, 7'h07, 7'h1B, 7'h0B, 7'h11, 7'h15, 7'h19};
  int n_mismatch = 0;
  int checks_done = 0;
  stac_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_trig_i(ext_trig_i), .ext_trig_o(ext_trig_o), .ext_trig_oe(ext_trig_oe),
    .sensor_integ(sensor_integ), .conv_start(conv_start), .conv_done(conv_done), .frame_valid(frame_valid));
  stac_conv_model u_conv (.ref_clk(ref_clk), .resetn(resetn), .conv_start(conv_start), .conv_done(conv_done));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(logic [7:0] a, logic [31:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(string name, logic [7:0] a, logic [31:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(name, exp, rdata);
  endtask
  task automatic wait_frame(string name);
    for (int i = 0; i < 4000; i++) begin
      @(posedge ref_clk);
      #1;
      if (frame_valid === 1'b1) break;
    end
    chk(name, 32'h00000001, 32'(frame_valid));
  endtask
  initial begin
    resetn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    ext_trig_i = 1'b0;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    rd_chk("ctrl", `STAC_OFS_CTRL, 32'h00000050);
    rd_chk("integ", `STAC_OFS_INTEG, 32'h000003E8);
    rd_chk("cmd", `STAC_OFS_CMD, 32'h00000000);
    rd_chk("unmapped", 8'h1C, 32'h00000000);
    wr_reg(`STAC_OFS_INTEG, 32'h00000005);
    rd_chk("integ clamp", `STAC_OFS_INTEG, 32'h0000001E);
    for (int p = 0; p < 2; p++) begin
      wr_reg(`STAC_OFS_CTRL, {25'h0, p[0], 6'h33});
      wr_reg(`STAC_OFS_CMD, 32'h00000001);
      #1 chk("integ start", 32'h00000001, 32'(sensor_integ));
      chk("pulse level", 32'(p[0]), 32'(ext_trig_o));
      chk("drive", 32'h00000001, 32'(ext_trig_oe));
      wr_reg(`STAC_OFS_CMD, 32'h00000001);
      wait_frame("sw sync frame");
    end
    rd_chk("drops", `STAC_OFS_DROPS, 32'h00000002);
    // each entry is parked in a quiet mode before its idle level is set
    foreach (tab[i]) begin
      wr_reg(`STAC_OFS_CTRL, 32'h00000010);
      // a free running measurement must end before the parked mode is taken up
      for (int w = 0; w < 1600 && sensor_integ !== 1'b0; w++) @(posedge ref_clk);
      repeat (30) @(posedge ref_clk);
      ext_trig_i <= ~tab[i][4];
      wr_reg(`STAC_OFS_CTRL, {25'h0, tab[i]});
      if (tab[i][3:1] == 3'h0) wr_reg(`STAC_OFS_CMD, 32'h00000001);
      @(posedge ref_clk);
      ext_trig_i <= tab[i][4];
      repeat (3) @(posedge ref_clk);
      ext_trig_i <= ~tab[i][4];
      wait_frame("triggered frame");
    end
    wr_reg(`STAC_OFS_CTRL, 32'h00000010);
    rd_chk("frames", `STAC_OFS_FRAMES, 32'h00000009);
    stop_test();
  end
  // the longest path is about eleven measurements of some 1600 cycles
  initial begin
    repeat (40000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
endmodule
